/* File: hw/return_and_rotate_consts.svh */
// constants for the return and rotate execution block
`ifndef RETURN_AND_ROTATE_CONSTS_SVH
`define RETURN_AND_ROTATE_CONSTS_SVH

// carrier widths
`define PC_WIDTH 21
`define RAM_ADDR_WIDTH 12

// instruction phases Q1..Q4
`define PHASE_Q1 2'h0
`define PHASE_Q2 2'h1
`define PHASE_Q3 2'h2
`define PHASE_Q4 2'h3

// opcode fields
`define RET_PREFIX 15'h0009
`define ROT_PREFIX 6'h0D
`define RESTORE_BIT 0
`define DEST_BIT 9
`define ACCESS_SEL_BIT 8

// flag bit positions
`define FLAG_CARRY 0
`define FLAG_ZERO 2
`define FLAG_NEG 4

// operand addressing
`define ACCESS_SPLIT 8'h80
`define INDEX_LIMIT 8'h5F
`define ACCESS_HIGH_BANK 4'hF
`define ACCESS_LOW_BANK 4'h0

// reset values
`define ACCUM_RESET 8'h00
`define FLAGS_RESET 5'h00
`define PAGE_RESET 8'h00
`define PC_RESET 21'h000000

`endif

/* File: hw/return_and_rotate_pkg.sv */
// types for the return and rotate execution block
`default_nettype none
`include "return_and_rotate_consts.svh"

package return_and_rotate_pkg;

  typedef enum logic [1:0] {
    OP_NONE,
    OP_RET,
    OP_ROT,
    OP_RET_WAIT
  } opState_e;

  // shadow copies taken by the core
  typedef struct packed {
    logic [7:0] accum;
    logic [4:0] flags;
    logic [7:0] page;
  } shadowSet_s;

  // writes to accumulator, flags and page selector from the rest of the core
  typedef struct packed {
    logic accumWr;
    logic [7:0] accum;
    logic flagsWr;
    logic [4:0] flags;
    logic pageWr;
    logic [7:0] page;
  } coreWrite_s;

  typedef struct packed {
    logic [1:0] phase;
    opState_e op;
    logic [15:0] instr;
    logic [7:0] operand;
    logic [7:0] result;
    logic [`PC_WIDTH-1:0] pc;
    logic stackPop;
    logic [`RAM_ADDR_WIDTH-1:0] ramAddr;
    logic ramWrEn;
    logic [7:0] ramWrData;
    logic [7:0] accum;
    logic [4:0] flags;
    logic [7:0] page;
    logic busy;
  } state_s;

endpackage : return_and_rotate_pkg

`default_nettype wire

/* File: hw/return_and_rotate_exec.sv */
// execution of return-from-subroutine and rotate-left-through-carry
`timescale 1ns/1ns
`default_nettype none
`include "return_and_rotate_consts.svh"

module return_and_rotate_exec #(
  parameter int PC_W = `PC_WIDTH,
  parameter int RAMA_W = `RAM_ADDR_WIDTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // instruction in
  input wire logic [15:0] instr,
  input wire logic instrValid,
  // return stack
  input wire logic [PC_W-1:0] stackHead,
  output logic stackPop,
  output logic [PC_W-1:0] pc,
  // shadows and core writes
  input wire return_and_rotate_pkg::shadowSet_s shadow,
  input wire return_and_rotate_pkg::coreWrite_s coreWr,
  // addressing mode
  input wire logic extEnable,
  input wire logic [RAMA_W-1:0] indexBase,
  // data ram
  output logic [RAMA_W-1:0] ramAddr,
  input wire logic [7:0] ramRdData,
  output logic ramWrEn,
  output logic [7:0] ramWrData,
  // core state
  output logic [7:0] accumulator,
  output logic [4:0] flags,
  output logic [7:0] ramPageSelector,
  output logic [1:0] phase,
  output logic busy
);

  // ****************************************
  // elaboration checks
  // ****************************************
  if (PC_W != `PC_WIDTH || RAMA_W != `RAM_ADDR_WIDTH)
  begin : g_width_check
    $error("return_and_rotate_exec: widths must match the carrier types");
  end

  if (`FLAG_CARRY > 4 || `FLAG_ZERO > 4 || `FLAG_NEG > 4)
  begin : g_flag_check
    $error("return_and_rotate_exec: flag positions must lie inside the flag register");
  end

  if (`INDEX_LIMIT >= `ACCESS_SPLIT)
  begin : g_split_check
    $error("return_and_rotate_exec: indexed window must lie below the access split");
  end

  if (`RESTORE_BIT != 0)
  begin : g_restore_check
    $error("return_and_rotate_exec: restore select must be the last opcode bit");
  end

  if (`DEST_BIT != `ACCESS_SEL_BIT + 1)
  begin : g_field_check
    $error("return_and_rotate_exec: destination bit must sit just above access select");
  end

  if ($bits(`ACCESS_HIGH_BANK) + 8 != RAMA_W)
  begin : g_bank_check
    $error("return_and_rotate_exec: bank prefix and offset must fill the address");
  end

  // ****************************************
  // decode helpers
  // ****************************************
  function automatic logic isReturn(input logic [15:0] word);
    isReturn = (word[15:1] == `RET_PREFIX);
  endfunction : isReturn

  function automatic logic isRotate(input logic [15:0] word);
    isRotate = (word[15:10] == `ROT_PREFIX);
  endfunction : isRotate

  function automatic logic writesBack(input logic [15:0] word);
    writesBack = word[`DEST_BIT];
  endfunction : writesBack

  function automatic logic [7:0] rotateLeft(input logic [7:0] value, input logic carryIn);
    rotateLeft = {value[6:0], carryIn};
  endfunction : rotateLeft

  function automatic logic [4:0] rotateFlags(
    input logic [4:0] flagsIn,
    input logic [7:0] operand,
    input logic [7:0] result
  );
    rotateFlags = flagsIn;
    rotateFlags[`FLAG_CARRY] = operand[7];
    rotateFlags[`FLAG_NEG] = result[7];
    rotateFlags[`FLAG_ZERO] = (result == 8'h00);
  endfunction : rotateFlags

  function automatic logic [RAMA_W-1:0] operandAddr(
    input logic [15:0] word,
    input logic [7:0] page,
    input logic ext,
    input logic [RAMA_W-1:0] base
  );
    logic [7:0] f;
    f = word[7:0];
    if (word[`ACCESS_SEL_BIT])
    begin
      operandAddr = {page[RAMA_W-9:0], f};
    end
    else if (ext && f <= `INDEX_LIMIT)
    begin
      // indexed window wraps within the address width
      operandAddr = RAMA_W'(base + RAMA_W'(f));
    end
    else if (f >= `ACCESS_SPLIT)
    begin
      // access bank: low half at 000h, high half at F80h
      operandAddr = {`ACCESS_HIGH_BANK, f};
    end
    else
    begin
      operandAddr = {`ACCESS_LOW_BANK, f};
    end
  endfunction : operandAddr

  // ****************************************
  // state
  // ****************************************
  return_and_rotate_pkg::state_s state_q;
  return_and_rotate_pkg::state_s state_d;

  always_comb
  begin
    state_d = state_q;
    state_d.phase = 2'(state_q.phase + 2'h1);
    state_d.stackPop = 1'b0;
    state_d.ramWrEn = 1'b0;

    // writes from the rest of the core
    if (coreWr.accumWr)
    begin
      state_d.accum = coreWr.accum;
    end
    if (coreWr.flagsWr)
    begin
      state_d.flags = coreWr.flags;
    end
    if (coreWr.pageWr)
    begin
      state_d.page = coreWr.page;
    end

    case (state_q.phase)
      `PHASE_Q1:
      begin
        // decode; a return's second cycle takes no new instruction
        if (state_q.op == return_and_rotate_pkg::OP_NONE && instrValid)
        begin
          state_d.instr = instr;
          if (isReturn(instr))
          begin
            state_d.op = return_and_rotate_pkg::OP_RET;
          end
          else if (isRotate(instr))
          begin
            state_d.op = return_and_rotate_pkg::OP_ROT;
            state_d.ramAddr = operandAddr(instr, state_d.page, extEnable, indexBase);
          end
          else
          begin
            state_d.op = return_and_rotate_pkg::OP_NONE;
          end
        end
      end
      `PHASE_Q2:
      begin
        // register read
        if (state_q.op == return_and_rotate_pkg::OP_ROT)
        begin
          state_d.operand = ramRdData;
        end
      end
      `PHASE_Q3:
      begin
        if (state_q.op == return_and_rotate_pkg::OP_ROT)
        begin
          // process: rotate left through carry
          state_d.result = rotateLeft(state_q.operand, state_q.flags[`FLAG_CARRY]);
          state_d.ramWrData = state_d.result;
          state_d.ramWrEn = writesBack(state_q.instr);
        end
        else if (state_q.op == return_and_rotate_pkg::OP_RET)
        begin
          // pop strobe stands through Q4
          state_d.stackPop = 1'b1;
        end
      end
      `PHASE_Q4:
      begin
        case (state_q.op)
          return_and_rotate_pkg::OP_ROT:
          begin
            if (!writesBack(state_q.instr))
            begin
              state_d.accum = state_q.result;
            end
            state_d.flags = rotateFlags(state_d.flags, state_q.operand, state_q.result);
            state_d.op = return_and_rotate_pkg::OP_NONE;
          end
          return_and_rotate_pkg::OP_RET:
          begin
            // counter latches are not held here and stay untouched
            state_d.pc = stackHead;
            if (state_q.instr[`RESTORE_BIT])
            begin
              state_d.accum = shadow.accum;
              state_d.flags = shadow.flags;
              state_d.page = shadow.page;
            end
            // restore bit zero keeps the values chosen above
            state_d.op = return_and_rotate_pkg::OP_RET_WAIT;
          end
          return_and_rotate_pkg::OP_RET_WAIT:
          begin
            state_d.op = return_and_rotate_pkg::OP_NONE;
          end
          default:
          begin
            state_d.op = return_and_rotate_pkg::OP_NONE;
          end
        endcase
      end
      default:
      begin
        state_d.phase = `PHASE_Q1;
      end
    endcase

    // busy leaves its own flop together with the op it mirrors
    state_d.busy = (state_d.op == return_and_rotate_pkg::OP_RET_WAIT);
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_q.phase <= `PHASE_Q1;
      state_q.op <= return_and_rotate_pkg::OP_NONE;
      state_q.instr <= 16'h0000;
      state_q.operand <= 8'h00;
      state_q.result <= 8'h00;
      state_q.pc <= `PC_RESET;
      state_q.stackPop <= 1'b0;
      state_q.ramAddr <= '0;
      state_q.ramWrEn <= 1'b0;
      state_q.ramWrData <= 8'h00;
      state_q.accum <= `ACCUM_RESET;
      state_q.flags <= `FLAGS_RESET;
      state_q.page <= `PAGE_RESET;
      state_q.busy <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign stackPop = state_q.stackPop;
  assign pc = state_q.pc;
  assign ramAddr = state_q.ramAddr;
  assign ramWrEn = state_q.ramWrEn;
  assign ramWrData = state_q.ramWrData;
  assign accumulator = state_q.accum;
  assign flags = state_q.flags;
  assign ramPageSelector = state_q.page;
  assign phase = state_q.phase;
  assign busy = state_q.busy;

endmodule : return_and_rotate_exec

`default_nettype wire

/* File: test/return_and_rotate_exec_properties.sv */
// checker for the return and rotate execution block
`timescale 1ns/1ns
`default_nettype none
module return_and_rotate_exec_properties (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // stack side
  input wire logic [20:0] stackHead,
  input wire logic stackPop,
  input wire logic [20:0] pc,
  // ram side
  input wire logic [7:0] ramRdData,
  input wire logic ramWrEn,
  input wire logic [7:0] ramWrData,
  // state
  input wire logic [4:0] flags,
  input wire logic [1:0] phase,
  input wire logic busy
);
  logic rdTop;
  assign rdTop = ramRdData[7];
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ************
  // assertions
  // ************
  a_pop_in_q4: assert property (stackPop |-> phase == 2'h3)
    else $error("pop outside Q4");
  a_pop_to_pc: assert property (stackPop |=> pc == $past(stackHead))
    else $error("pc not loaded from stack");
  a_pc_held: assert property ($changed(pc) && !$past(rst) |-> $past(stackPop))
    else $error("pc changed without pop");
  a_idle_cycle: assert property (stackPop |=> busy [*4] ##1 !busy)
    else $error("idle cycle length wrong");
  a_busy_no_op: assert property (busy |-> !stackPop && !ramWrEn)
    else $error("activity in idle cycle");
  a_wr_in_q4: assert property (ramWrEn |-> phase == 2'h3)
    else $error("write outside Q4");
  a_wr_single: assert property (ramWrEn |=> !ramWrEn)
    else $error("write longer than one cycle");
  a_rot_shift: assert property (ramWrEn |-> ramWrData == {ramRdData[6:0], flags[0]})
    else $error("rotate result wrong");
  a_rot_flags: assert property (ramWrEn |=> flags[0] == $past(rdTop)
    && flags[4] == $past(ramWrData[7]) && flags[2] == ($past(ramWrData) == 8'h00))
    else $error("rotate flags wrong");
  cover property (stackPop ##1 busy);
  cover property (ramWrEn);
  cover property (busy ##1 !busy);
endmodule : return_and_rotate_exec_properties
`default_nettype wire

/* File: test/return_and_rotate_exec_test.sv */
// testbench for the return and rotate execution block
`timescale 1ns/1ns
`default_nettype none
module return_and_rotate_exec_test;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] instr = 16'h0000;
  logic instrValid = 1'b0;
  logic [20:0] stackHead = 21'h1ABCD5;
  return_and_rotate_pkg::shadowSet_s shadow = '{8'hC3, 5'h15, 8'h0A};
  return_and_rotate_pkg::coreWrite_s coreWr = '0;
  logic extEnable = 1'b0;
  logic [11:0] indexBase = 12'h100;
  logic stackPop, ramWrEn, busy;
  logic [20:0] pc;
  logic [11:0] ramAddr;
  logic [7:0] ramRdData, ramWrData, accumulator, ramPageSelector;
  logic [4:0] flags;
  logic [1:0] phase;
  logic [7:0] acc = 8'h00;
  logic [7:0] pg = 8'h00;
  logic [4:0] fl = 5'h00;
  int n_mismatch = 0;
  int checked = 0;
  // ram answers with a pattern of its address
  assign ramRdData = ramAddr[7:0] ^ 8'h5A;
  always #10 clk = ~clk;
  return_and_rotate_exec u_dut (.clk, .rst, .instr, .instrValid, .stackHead,
    .stackPop, .pc, .shadow, .coreWr, .extEnable, .indexBase, .ramAddr,
    .ramRdData, .ramWrEn, .ramWrData, .accumulator, .flags,
    .ramPageSelector, .phase, .busy);
  // ************
  // tasks
  // ************
  task complete_run;
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  task chk(input logic [20:0] g, input logic [20:0] e);
    checked++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("FAIL %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  // ends at the Q2 cycle
  task issue(input logic [15:0] w);
    @(negedge clk);
    while (phase !== 2'h0) @(negedge clk);
    instr = w;
    instrValid = 1'b1;
    @(negedge clk);
    instrValid = 1'b0;
  endtask : issue
  task rot(input logic [15:0] w, input logic [11:0] ea);
    logic [7:0] rd;
    logic [7:0] r;
    rd = ea[7:0] ^ 8'h5A;
    r = {rd[6:0], fl[0]};
    issue(w);
    chk(ramAddr, ea);
    repeat (2) @(negedge clk);
    chk(ramWrEn, w[9]);
    chk(phase, 2'h3);
    if (w[9]) chk(ramWrData, r);
    fl = {r[7], fl[3], r == 8'h00, fl[1], rd[7]};
    if (!w[9]) acc = r;
    @(negedge clk);
    chk(flags, fl);
    chk(accumulator, acc);
  endtask : rot
  task ret(input logic s);
    issue({15'h0009, s});
    repeat (2) @(negedge clk);
    chk(stackPop, 1'b1);
    if (s)
    begin
      acc = shadow.accum;
      fl = shadow.flags;
      pg = shadow.page;
    end
    @(negedge clk);
    chk(pc, stackHead);
    chk({accumulator, flags, ramPageSelector}, {acc, fl, pg});
    // rotate offered in the idle cycle must be dropped
    instr = 16'h3400;
    instrValid = 1'b1;
    repeat (3) @(negedge clk);
    chk({busy, ramWrEn}, 2'h2);
    @(negedge clk);
    instrValid = 1'b0;
    chk(busy, 1'b0);
    chk(accumulator, acc);
  endtask : ret
  // ************
  // sequence
  // ************
  initial
  begin
    repeat (10) @(negedge clk);
    rst = 1'b0;
    coreWr = '{1'b1, 8'h5C, 1'b1, 5'h04, 1'b1, 8'h03};
    @(negedge clk);
    coreWr = '0;
    acc = 8'h5C;
    fl = 5'h04;
    pg = 8'h03;
    chk({accumulator, flags, ramPageSelector}, {acc, fl, pg});
    rot(16'h3712, 12'h312);
    rot(16'h34A0, 12'hFA0);
    rot(16'h345A, 12'h05A);
    extEnable = 1'b1;
    rot(16'h345F, 12'h15F);
    rot(16'h3460, 12'h060);
    rot(16'h3620, 12'h120);
    rot(16'h3520, 12'h320);
    issue(16'h0011);
    repeat (2) @(negedge clk);
    chk(stackPop, 1'b0);
    ret(1'b0);
    ret(1'b1);
    rot(16'h3401, 12'h101);
    complete_run();
  end
  initial
  begin
    #20000;
    n_mismatch++;
    complete_run();
  end
endmodule : return_and_rotate_exec_test
bind return_and_rotate_exec return_and_rotate_exec_properties u_props (.clk, .rst,
  .stackHead, .stackPop, .pc, .ramRdData, .ramWrEn, .ramWrData, .flags, .phase, .busy);
`default_nettype wire
